// >>> inc/bdvs_pkg.sv
// constants, types and register map of the buck target-voltage register bank
package bdvs_pkg;

    // bus slave address (7-bit) and register offsets
    localparam logic [6:0] BDVS_SLAVE_ADDR = 7'h3C;
    localparam logic [7:0] BDVS_OFS_BUCK1_NORMAL = 8'h17;
    localparam logic [7:0] BDVS_OFS_BUCK0_SCALED = 8'h1B;
    localparam logic [7:0] BDVS_OFS_BUCK1_SCALED = 8'h1C;

    // reset values
    localparam logic [7:0] BDVS_RST_BUCK0_SCALED = 8'h20;
    localparam logic [7:0] BDVS_RST_BUCK1_SCALED = 8'h10;
    localparam logic [7:0] BDVS_RST_ZERO = 8'h00;

    // factory field of the second buck's normal setting: bits 6..2
    localparam int BDVS_OTP_LSB = 2;
    localparam int BDVS_OTP_MSB = 6;
    localparam int BDVS_OTP_W = BDVS_OTP_MSB - BDVS_OTP_LSB + 1;

    // highest writable code per buck table
    localparam logic [7:0] BDVS_MAX_CODE_BUCK0 = 8'h40;
    localparam logic [7:0] BDVS_MAX_CODE_BUCK1 = 8'h4C;
    // codes at or below this are reserved in every step-down table
    localparam logic [7:0] BDVS_MAX_RESERVED_CODE = 8'h01;

    // serial bit counting
    localparam logic [3:0] BDVS_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BDVS_LAST_TX_BIT = 4'h7;
    localparam logic [3:0] BDVS_CNT_ZERO = 4'h0;
    localparam logic [3:0] BDVS_CNT_ONE = 4'h1;
    localparam logic [7:0] BDVS_PTR_STEP = 8'h01;

    // number of scaled bucks
    localparam int BDVS_NBUCK = 2;

    // serial slave states
    typedef enum logic [2:0] {
        BDVS_ST_IDLE = 3'b000,
        BDVS_ST_ADDR = 3'b001,
        BDVS_ST_REG = 3'b010,
        BDVS_ST_WDATA = 3'b011,
        BDVS_ST_ACK = 3'b100,
        BDVS_ST_TX = 3'b101,
        BDVS_ST_TXACK = 3'b110,
        BDVS_ST_TXLD = 3'b111
    } bdvs_state_e;

    // pin-controlled scaling configuration from the general-purpose pin block
    typedef struct packed {
        logic pin_five_alt_enable; // 1 = pin five steers buck zero
        logic pin_five_polarity;   // 1 = pin five active-high
        logic pin_six_alt_enable;  // 1 = pin six steers buck one
        logic pin_six_polarity;    // 1 = pin six active-high
    } bdvs_dvs_ctrl_s;

endpackage

// >>> rtl/bdvs_regs.sv
// buck target-voltage registers with serial slave and pin-driven scaling select
`timescale 1ns/1ns
`default_nettype none
// How it works
// - answer serial accesses at slave address 0x3C
// - second buck normal setting register at 0x17
// - reset loads bit7, bits1:0 zero, rest factory
// - first buck scaled register 0x1B, reset 0x20
// - second buck scaled register 0x1C, reset 0x10
// - pin five steers first buck when enabled
// - active pin five picks scaled, else normal
// - pin six steers second buck when enabled
// - active pin six picks second buck scaled
// - inactive pin six picks second buck normal
// - codes 0x00 and 0x01 are reserved
// - second buck writes above 0x4C ignored
// - first buck writes above 0x40 ignored
module bdvs_regs
(
    input wire logic sys_clk, // 250 MHz system clock
    input wire logic nrst, // asynchronous reset, active low
    input wire logic global_shutdown, // one-cycle pulse, returns registers to reset values
    input wire logic [bdvs_pkg::BDVS_OTP_W-1:0] otp_buck1_bits, // factory bits for 6..2
    input wire logic [7:0] buck0_normal_target, // first buck normal code, held elsewhere
    input wire bdvs_pkg::bdvs_dvs_ctrl_s dvs_ctrl, // alternate-mode and polarity bits
    input wire logic general_io_pin_five, // asynchronous pin, scaling select for buck zero
    input wire logic general_io_pin_six, // asynchronous pin, scaling select for buck one
    input wire logic scl_in, // serial clock pin
    input wire logic sda_in, // serial data pin level
    output logic sda_out, // serial data drive value, always low
    output logic sda_oe, // serial data drive enable, high pulls line low
    output logic [7:0] buck0_target_code, // selected first buck target code
    output logic [7:0] buck1_target_code, // selected second buck target code
    output logic buck0_code_reserved, // selected first buck code is reserved
    output logic buck1_code_reserved // selected second buck code is reserved
);
    import bdvs_pkg::*;

    // pin synchronisers: stage one is read only by stage two
    logic [3:0] sync1_reg; // first stage: scl, sda, pin five, pin six
    logic [3:0] sync2_reg; // second stage
    logic [1:0] bus_prev_reg; // previous scl, sda for edge detection
    // serial slave state
    bdvs_state_e st_reg, st_next; // slave state
    bdvs_state_e after_ack_reg, after_ack_next; // state following an ack
    logic [7:0] sh_reg, sh_next; // shift register
    logic [3:0] cnt_reg, cnt_next; // bit counter
    logic [7:0] ptr_reg, ptr_next; // register pointer
    logic oe_reg, oe_next; // data line pull-down
    logic wr_en; // accepted data byte strobe
    logic [7:0] rd_byte; // read data at pointer
    // register bank state
    logic [7:0] buck1_normal_target_reg, buck1_normal_target_next; // second buck normal
    logic [7:0] buck0_scaled_target_reg, buck0_scaled_target_next; // first buck scaled
    logic [7:0] buck1_scaled_target_reg, buck1_scaled_target_next; // second buck scaled
    logic otp_loaded_reg, otp_loaded_next; // factory bits captured
    // target selection state, one entry per buck
    logic [7:0] tgt_reg [BDVS_NBUCK], tgt_next [BDVS_NBUCK]; // selected code
    logic rsv_reg [BDVS_NBUCK], rsv_next [BDVS_NBUCK]; // reserved flag
    // synchronised levels, edges and start/stop conditions
    wire logic scl_s = sync2_reg[0]; // serial clock level
    wire logic sda_s = sync2_reg[1]; // serial data level
    wire logic scl_rise = scl_s & ~bus_prev_reg[0]; // clock rose
    wire logic scl_fall = ~scl_s & bus_prev_reg[0]; // clock fell
    wire logic bus_start = scl_s & bus_prev_reg[0] & bus_prev_reg[1] & ~sda_s; // start
    wire logic bus_stop = scl_s & bus_prev_reg[0] & ~bus_prev_reg[1] & sda_s; // stop
    // two-flop synchroniser and edge history
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
            bus_prev_reg <= 2'h3;
        end
        else
        begin
            sync1_reg <= {general_io_pin_six, general_io_pin_five, sda_in, scl_in};
            sync2_reg <= sync1_reg;
            bus_prev_reg <= sync2_reg[1:0];
        end
    end
    // read mux, unmapped offsets read zero
    always_comb
    begin
        case (ptr_reg)
            BDVS_OFS_BUCK1_NORMAL: rd_byte = buck1_normal_target_reg;
            BDVS_OFS_BUCK0_SCALED: rd_byte = buck0_scaled_target_reg;
            BDVS_OFS_BUCK1_SCALED: rd_byte = buck1_scaled_target_reg;
            default: rd_byte = BDVS_RST_ZERO;
        endcase
    end
    // serial slave next state
    always_comb
    begin
        st_next = st_reg;
        after_ack_next = after_ack_reg;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        ptr_next = ptr_reg;
        oe_next = oe_reg;
        wr_en = 1'b0;
        if (bus_stop)
        begin
            st_next = BDVS_ST_IDLE; // stop releases the line and idles
            oe_next = 1'b0;
        end
        else if (bus_start)
        begin
            st_next = BDVS_ST_ADDR; // start or repeated start: address byte next
            cnt_next = BDVS_CNT_ZERO;
            oe_next = 1'b0;
        end
        else
        begin
            case (st_reg)
                BDVS_ST_IDLE: oe_next = 1'b0;
                BDVS_ST_ADDR, BDVS_ST_REG, BDVS_ST_WDATA:
                begin
                    if (scl_rise && cnt_reg != BDVS_BITS_PER_BYTE)
                    begin
                        sh_next = {sh_reg[6:0], sda_s}; // sample one bit, msb first
                        cnt_next = cnt_reg + BDVS_CNT_ONE;
                    end
                    else if (scl_fall && cnt_reg == BDVS_BITS_PER_BYTE)
                    begin
                        oe_next = 1'b1; // whole byte in: act on it and acknowledge
                        st_next = BDVS_ST_ACK;
                        if (st_reg == BDVS_ST_ADDR)
                        begin
                            if (sh_reg[7:1] == BDVS_SLAVE_ADDR)
                                after_ack_next = sh_reg[0] ? BDVS_ST_TX : BDVS_ST_REG;
                            else
                            begin
                                oe_next = 1'b0; // other address: stay off the line
                                st_next = BDVS_ST_IDLE;
                            end
                        end
                        else if (st_reg == BDVS_ST_REG)
                        begin
                            ptr_next = sh_reg; // pointer byte
                            after_ack_next = BDVS_ST_WDATA;
                        end
                        else
                        begin
                            wr_en = 1'b1; // data byte: write and advance pointer
                            ptr_next = ptr_reg + BDVS_PTR_STEP;
                            after_ack_next = BDVS_ST_WDATA;
                        end
                    end
                end
                BDVS_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_next = BDVS_CNT_ZERO;
                        if (after_ack_reg == BDVS_ST_TX)
                        begin
                            sh_next = rd_byte; // read: put out first data bit
                            oe_next = ~rd_byte[7];
                            st_next = BDVS_ST_TX;
                        end
                        else
                        begin
                            oe_next = 1'b0;
                            st_next = after_ack_reg;
                        end
                    end
                end
                BDVS_ST_TX:
                begin
                    if (scl_fall)
                    begin
                        if (cnt_reg == BDVS_LAST_TX_BIT)
                        begin
                            oe_next = 1'b0; // byte sent: release for master ack
                            st_next = BDVS_ST_TXACK;
                        end
                        else
                        begin
                            sh_next = {sh_reg[6:0], 1'b0};
                            oe_next = ~sh_reg[6];
                            cnt_next = cnt_reg + BDVS_CNT_ONE;
                        end
                    end
                end
                BDVS_ST_TXACK:
                begin
                    if (scl_rise)
                    begin
                        st_next = sda_s ? BDVS_ST_IDLE : BDVS_ST_TXLD; // nack ends, ack advances
                        ptr_next = sda_s ? ptr_reg : ptr_reg + BDVS_PTR_STEP;
                    end
                end
                BDVS_ST_TXLD:
                begin
                    if (scl_fall)
                    begin
                        sh_next = rd_byte; // next byte of a burst read
                        oe_next = ~rd_byte[7];
                        cnt_next = BDVS_CNT_ZERO;
                        st_next = BDVS_ST_TX;
                    end
                end
                default:
                begin
                    st_next = BDVS_ST_IDLE;
                    oe_next = 1'b0;
                end
            endcase
        end
    end
    // serial slave registers
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= BDVS_ST_IDLE;
            after_ack_reg <= BDVS_ST_IDLE;
            sh_reg <= BDVS_RST_ZERO;
            cnt_reg <= BDVS_CNT_ZERO;
            ptr_reg <= BDVS_RST_ZERO;
            oe_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            after_ack_reg <= after_ack_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            ptr_reg <= ptr_next;
            oe_reg <= oe_next;
        end
    end
    // register bank next values: shutdown, factory load, filtered writes
    always_comb
    begin
        buck1_normal_target_next = buck1_normal_target_reg;
        buck0_scaled_target_next = buck0_scaled_target_reg;
        buck1_scaled_target_next = buck1_scaled_target_reg;
        otp_loaded_next = otp_loaded_reg;
        if (global_shutdown)
        begin
            buck1_normal_target_next = BDVS_RST_ZERO;
            buck0_scaled_target_next = BDVS_RST_BUCK0_SCALED;
            buck1_scaled_target_next = BDVS_RST_BUCK1_SCALED;
            otp_loaded_next = 1'b0; // back to reset values, factory bits reload next cycle
        end
        else if (!otp_loaded_reg)
        begin
            buck1_normal_target_next = BDVS_RST_ZERO;
            buck1_normal_target_next[BDVS_OTP_MSB:BDVS_OTP_LSB] = otp_buck1_bits;
            otp_loaded_next = 1'b1; // bit 7 and bits 1:0 zero, bits 6:2 from factory
        end
        else if (wr_en)
        begin
            case (ptr_reg)
                BDVS_OFS_BUCK1_NORMAL:
                    if (sh_reg <= BDVS_MAX_CODE_BUCK1)
                        buck1_normal_target_next = sh_reg;
                BDVS_OFS_BUCK0_SCALED:
                    if (sh_reg <= BDVS_MAX_CODE_BUCK0)
                        buck0_scaled_target_next = sh_reg;
                BDVS_OFS_BUCK1_SCALED:
                    if (sh_reg <= BDVS_MAX_CODE_BUCK1)
                        buck1_scaled_target_next = sh_reg;
                default: otp_loaded_next = otp_loaded_reg; // unmapped offset: write dropped
            endcase
        end
    end
    // register bank flops
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            buck1_normal_target_reg <= BDVS_RST_ZERO;
            buck0_scaled_target_reg <= BDVS_RST_BUCK0_SCALED;
            buck1_scaled_target_reg <= BDVS_RST_BUCK1_SCALED;
            otp_loaded_reg <= 1'b0;
        end
        else
        begin
            buck1_normal_target_reg <= buck1_normal_target_next;
            buck0_scaled_target_reg <= buck0_scaled_target_next;
            buck1_scaled_target_reg <= buck1_scaled_target_next;
            otp_loaded_reg <= otp_loaded_next;
        end
    end
    // per-buck target selection
    genvar gi;
    generate
        for (gi = 0; gi < BDVS_NBUCK; gi = gi + 1)
        begin : g_sel
            logic en; // alternate mode enabled
            logic pol; // 1 = active-high pin
            logic pin; // synchronised pin level
            logic [7:0] normal_code; // normal setting for this buck
            logic [7:0] scaled_code; // scaled setting for this buck
            // per-buck sources; active pin with enable picks scaled, otherwise normal
            always_comb
            begin
                en = (gi == 0) ? dvs_ctrl.pin_five_alt_enable : dvs_ctrl.pin_six_alt_enable;
                pol = (gi == 0) ? dvs_ctrl.pin_five_polarity : dvs_ctrl.pin_six_polarity;
                pin = sync2_reg[gi + 2];
                normal_code = (gi == 0) ? buck0_normal_target : buck1_normal_target_reg;
                scaled_code = (gi == 0) ? buck0_scaled_target_reg : buck1_scaled_target_reg;
                if (en && (pin == pol))
                    tgt_next[gi] = scaled_code;
                else
                    tgt_next[gi] = normal_code;
                rsv_next[gi] = (tgt_next[gi] <= BDVS_MAX_RESERVED_CODE);
            end
            // selection flops
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    tgt_reg[gi] <= BDVS_RST_ZERO;
                    rsv_reg[gi] <= 1'b0;
                end
                else
                begin
                    tgt_reg[gi] <= tgt_next[gi];
                    rsv_reg[gi] <= rsv_next[gi];
                end
            end
        end
    endgenerate
    // outputs straight from flops, sda_out tied low
    assign buck0_target_code = tgt_reg[0];
    assign buck1_target_code = tgt_reg[1];
    assign buck0_code_reserved = rsv_reg[0];
    assign buck1_code_reserved = rsv_reg[1];
    assign sda_oe = oe_reg;
    assign sda_out = 1'b0; // open drain: only the enable moves
endmodule
`default_nettype wire

// >>> verif/bdvs_regs_monitor.sv
// port checks for the buck target-voltage register bank
`timescale 1ns/1ns
`default_nettype none
module bdvs_regs_monitor
(
    input wire logic sys_clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic global_shutdown, // shutdown pulse
    input wire logic [bdvs_pkg::BDVS_OTP_W-1:0] otp_buck1_bits, // factory bits
    input wire logic [7:0] buck0_normal_target, // buck zero normal code
    input wire bdvs_pkg::bdvs_dvs_ctrl_s dvs_ctrl, // scaling control
    input wire logic general_io_pin_five, // pin five
    input wire logic general_io_pin_six, // pin six
    input wire logic scl_in, // serial clock
    input wire logic sda_oe, // data pull enable
    input wire logic [7:0] buck0_target_code, // buck zero code
    input wire logic [7:0] buck1_target_code, // buck one code
    input wire logic buck0_code_reserved, // buck zero reserved flag
    input wire logic buck1_code_reserved // buck one reserved flag
);
    import bdvs_pkg::*;
    logic [1:0] age_reg; // cycles since reset release, saturating
    logic [1:0] age_next; // next count
    // count to three so the first edges after reset are skipped
    always_comb
    begin
        age_next = (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
    end
    // register the count
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            age_reg <= 2'h0;
        else
            age_reg <= age_next;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    property p_buck0_normal;
        age_reg == 2'h3 && !dvs_ctrl.pin_five_alt_enable
            |=> buck0_target_code == $past(buck0_normal_target);
    endproperty
    a_buck0_normal: assert property (p_buck0_normal) else $error("buck0 normal");
    property p_buck0_idle_pin;
        (age_reg == 2'h3 && dvs_ctrl.pin_five_alt_enable && $stable(dvs_ctrl)
            && general_io_pin_five != dvs_ctrl.pin_five_polarity
            && $stable(general_io_pin_five) && $stable(buck0_normal_target))[*4]
            |-> buck0_target_code == buck0_normal_target;
    endproperty
    a_buck0_idle_pin: assert property (p_buck0_idle_pin) else $error("buck0 idle");
    property p_buck1_shut_normal;
        global_shutdown ##1 (!global_shutdown && !dvs_ctrl.pin_six_alt_enable)[*3]
            |-> buck1_target_code == {1'b0, otp_buck1_bits, 2'h0};
    endproperty
    a_buck1_shut_normal: assert property (p_buck1_shut_normal) else $error("buck1 otp");
    property p_buck0_shut_scaled;
        global_shutdown ##1 (!global_shutdown && dvs_ctrl.pin_five_alt_enable
            && general_io_pin_five == dvs_ctrl.pin_five_polarity)[*4]
            |-> buck0_target_code == BDVS_RST_BUCK0_SCALED;
    endproperty
    a_buck0_shut_scaled: assert property (p_buck0_shut_scaled) else $error("buck0 rst");
    property p_buck1_shut_scaled;
        global_shutdown ##1 (!global_shutdown && dvs_ctrl.pin_six_alt_enable
            && general_io_pin_six == dvs_ctrl.pin_six_polarity)[*4]
            |-> buck1_target_code == BDVS_RST_BUCK1_SCALED;
    endproperty
    a_buck1_shut_scaled: assert property (p_buck1_shut_scaled) else $error("buck1 rst");
    property p_reserved0;
        age_reg == 2'h3 |-> buck0_code_reserved == (buck0_target_code <= 8'h01);
    endproperty
    a_reserved0: assert property (p_reserved0) else $error("buck0 reserved");
    property p_reserved1;
        age_reg == 2'h3 |-> buck1_code_reserved == (buck1_target_code <= 8'h01);
    endproperty
    a_reserved1: assert property (p_reserved1) else $error("buck1 reserved");
    property p_oe_stands;
        scl_in && sda_oe |-> $past(sda_oe);
    endproperty
    a_oe_stands: assert property (p_oe_stands) else $error("data drive moved");
endmodule
`default_nettype wire

// >>> verif/bdvs_host_model.sv
// serial bus master standing in for the application processor
`timescale 1ns/1ns
`default_nettype none
module bdvs_host_model
(
    input wire logic sys_clk, // pacing clock
    input wire logic sda_line, // resolved data level
    output logic scl_drv, // serial clock
    output logic sda_pull // 1 pulls data low
);
    import bdvs_pkg::*;
    // bus idles released
    initial
    begin
        scl_drv = 1'b1;
        sda_pull = 1'b0;
    end
    // wait n falling clock edges
    task automatic clk_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // start (a=0,b=1) or stop (a=1,b=0): data moves while the clock is high
    task automatic cond(input logic a, input logic b);
        clk_n(4);
        sda_pull = a;
        clk_n(4);
        scl_drv = 1'b1;
        clk_n(8);
        sda_pull = b;
        clk_n(8);
        scl_drv = !b;
    endtask
    // one bit slot: data moves mid-low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        clk_n(4);
        sda_pull = !b;
        clk_n(4);
        scl_drv = 1'b1;
        clk_n(8);
        r = sda_line;
        scl_drv = 1'b0;
    endtask
    // eight bits msb first, then the ninth slot sending level nine
    task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] q,
        output logic nak);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(nine, nak);
    endtask
    // register write; ok when all three bytes were acknowledged
    task automatic write_reg(input logic [6:0] sa, input logic [7:0] ofs,
        input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic n0, n1, n2;
        cond(1'b0, 1'b1);
        byte_io({sa, 1'b0}, 1'b1, q, n0);
        byte_io(ofs, 1'b1, q, n1);
        byte_io(d, 1'b1, q, n2);
        cond(1'b1, 1'b0);
        ok = !(n0 | n1 | n2);
    endtask
    // register read: pointer, repeated start, one byte closed by a nack
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic [7:0] q;
        logic n;
        cond(1'b0, 1'b1);
        byte_io({BDVS_SLAVE_ADDR, 1'b0}, 1'b1, q, n);
        byte_io(ofs, 1'b1, q, n);
        cond(1'b0, 1'b1);
        byte_io({BDVS_SLAVE_ADDR, 1'b1}, 1'b1, q, n);
        byte_io(8'hFF, 1'b1, d, n);
        cond(1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// >>> verif/bdvs_regs_test.sv
// self-checking bench for the buck target-voltage register bank
`timescale 1ns/1ns
`default_nettype none
module bdvs_regs_test;
    import bdvs_pkg::*;
    logic sys_clk = 1'b0; // clock
    logic nrst = 1'b0; // reset, active low
    logic shut = 1'b0; // shutdown pulse
    logic [BDVS_OTP_W-1:0] otp = 5'h15; // factory bits
    logic [7:0] nt0 = 8'h00; // buck zero normal code
    bdvs_dvs_ctrl_s ctrl = 4'h0; // scaling control
    logic p5 = 1'b0; // pin five
    logic p6 = 1'b0; // pin six
    wire logic scl, pull, sdo, soe, r0, r1; // bus and flags
    wire logic [7:0] c0, c1; // selected codes
    wire logic sda = (soe ? sdo : 1'b1) & !pull; // pulled-up data line
    wire logic [7:0] exp17 = {1'b0, otp, 2'h0}; // normal reset value
    int err_total = 0; // mismatches
    int num_checks = 0; // comparisons
    always #2 sys_clk = ~sys_clk;
    bdvs_regs bdvs_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .global_shutdown(shut),
        .otp_buck1_bits(otp), .buck0_normal_target(nt0), .dvs_ctrl(ctrl),
        .general_io_pin_five(p5), .general_io_pin_six(p6), .scl_in(scl), .sda_in(sda),
        .sda_out(sdo), .sda_oe(soe), .buck0_target_code(c0), .buck1_target_code(c1),
        .buck0_code_reserved(r0), .buck1_code_reserved(r1));
    bdvs_host_model bdvs_host_model_inst (.sys_clk(sys_clk), .sda_line(sda),
        .scl_drv(scl), .sda_pull(pull));
    // byte comparison
    task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // flag comparison
    task automatic chk1(input string what, input logic e, input logic g);
        num_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // bus write, acknowledge judged
    task automatic wr(input logic [6:0] sa, input logic [7:0] o, input logic [7:0] d,
        input logic e);
        logic ok;
        bdvs_host_model_inst.write_reg(sa, o, d, ok);
        chk1("write ack", e, ok);
    endtask
    // bus read, data judged
    task automatic rd(input logic [7:0] o, input logic [7:0] e);
        logic [7:0] d;
        bdvs_host_model_inst.read_reg(o, d);
        chk8("read data", e, d);
    endtask
    // one-cycle shutdown, then settle
    task automatic pulse;
        shut = 1'b1;
        @(negedge sys_clk);
        shut = 1'b0;
        repeat (5) @(negedge sys_clk);
    endtask
    // reset values and an unmapped offset
    task automatic t_reset_values;
        rd(BDVS_OFS_BUCK1_NORMAL, exp17);
        rd(BDVS_OFS_BUCK0_SCALED, BDVS_RST_BUCK0_SCALED);
        rd(BDVS_OFS_BUCK1_SCALED, BDVS_RST_BUCK1_SCALED);
        rd(8'h18, 8'h00);
    endtask
    // codes at and above each table top, and a foreign slave address
    task automatic t_write_limits;
        logic [7:0] ofs [7] = '{8'h1B, 8'h1B, 8'h1C, 8'h1C, 8'h1C, 8'h17, 8'h17};
        logic [7:0] dat [7] = '{8'h40, 8'h41, 8'h4C, 8'h4D, 8'h00, 8'h4C, 8'hFF};
        logic [7:0] want [7] = '{8'h40, 8'h40, 8'h4C, 8'h4C, 8'h00, 8'h4C, 8'h4C};
        for (int i = 0; i < 7; i++)
        begin
            wr(BDVS_SLAVE_ADDR, ofs[i], dat[i], 1'b1);
            rd(ofs[i], want[i]);
        end
        wr(7'h3D, 8'h1B, 8'h05, 1'b0);
        rd(8'h1B, 8'h40);
    endtask
    // all enable, polarity and level combinations on both pins
    task automatic t_pin_select;
        logic a0, a1;
        nt0 = 8'h01;
        for (int v = 0; v < 64; v++)
        begin
            ctrl = {v[5], v[4], v[2], v[1]};
            p5 = v[3];
            p6 = v[0];
            a0 = v[5] && (v[3] == v[4]);
            a1 = v[2] && (v[0] == v[1]);
            repeat (5) @(negedge sys_clk);
            chk8("buck0 code", a0 ? 8'h40 : 8'h01, c0);
            chk8("buck1 code", a1 ? 8'h00 : 8'h4C, c1);
            chk1("buck0 reserved", !a0, r0);
            chk1("buck1 reserved", a1, r1);
        end
        ctrl = 4'h0;
        nt0 = 8'h02;
        repeat (2) @(negedge sys_clk);
        chk1("buck0 reserved", 1'b0, r0);
    endtask
    // shutdown with pins idle, then with both pins selecting scaled codes
    task automatic t_shutdown;
        pulse();
        chk8("buck1 code", exp17, c1);
        wr(BDVS_SLAVE_ADDR, 8'h1B, 8'h3F, 1'b1);
        wr(BDVS_SLAVE_ADDR, 8'h1C, 8'h3E, 1'b1);
        ctrl = 4'hB;
        p5 = 1'b0;
        p6 = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk8("buck0 code", 8'h3F, c0);
        chk8("buck1 code", 8'h3E, c1);
        pulse();
        chk8("buck0 code", BDVS_RST_BUCK0_SCALED, c0);
        chk8("buck1 code", BDVS_RST_BUCK1_SCALED, c1);
        rd(BDVS_OFS_BUCK1_NORMAL, exp17);
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) @(negedge sys_clk);
        t_reset_values();
        t_write_limits();
        t_pin_select();
        t_shutdown();
        tally_and_finish();
    end
    // hang guard
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        err_total++;
        tally_and_finish();
    end
endmodule
bind bdvs_regs bdvs_regs_monitor bdvs_regs_monitor_inst (.sys_clk(sys_clk), .nrst(nrst),
    .global_shutdown(global_shutdown), .otp_buck1_bits(otp_buck1_bits),
    .buck0_normal_target(buck0_normal_target), .dvs_ctrl(dvs_ctrl),
    .general_io_pin_five(general_io_pin_five), .general_io_pin_six(general_io_pin_six),
    .scl_in(scl_in), .sda_oe(sda_oe), .buck0_target_code(buck0_target_code),
    .buck1_target_code(buck1_target_code), .buck0_code_reserved(buck0_code_reserved),
    .buck1_code_reserved(buck1_code_reserved));
`default_nettype wire
